// ==== bcs_params.svh ====
/*
  Offsets, field positions, reset values and decode constants of the
  board control and status register file.
  Assumes bit 0 of each word is the most significant; it rides on host bus line 31.
*/
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH

// =====================================================================
// Address map
`define BCS_REGION_BYTES 32768
`define BCS_ADDR_MSB 14
`define BCS_IDX_MSB 4
`define BCS_IDX_LSB 2
`define BCS_OFS_HRC 3'h0
`define BCS_OFS_SECOND 3'h1
`define BCS_OFS_THIRD 3'h2
`define BCS_OFS_FOURTH 3'h3
`define BCS_OFS_FIFTH 3'h4
`define BCS_DATA_MSB 31
`define BCS_DATA_LSB 16

// =====================================================================
// Power-on values, bit 0 on the left
`define BCS_HRC_RESET 16'h0100
`define BCS_R1_RESET 16'h39b0
`define BCS_R2_RESET 16'h0000
`define BCS_R3_RESET 16'h0000
`define BCS_R4_RESET 16'h0000

// =====================================================================
// Field positions, counted from bit 0 on the left
`define BCS_R1_FLASH_CFG 4
`define BCS_R1_UNLOCK 5
`define BCS_R1_MAPEN 6
`define BCS_R3_UNLOCK 0

// =====================================================================
// Decoded configuration values
`define BCS_IPFX_HI 32'hfff00000
`define BCS_IPFX_LO 32'h00000000
`define BCS_BASE_00 32'h00000000
`define BCS_BASE_01 32'h00f00000
`define BCS_BASE_1X 32'hff000000

`endif

// ==== bcs_pkg.sv ====
/*
  Types of the board control and status register file.
  Assumes the bus word is held with bit 0 as its most significant bit.
*/
package bcs_pkg;

  // ===================================================================
  // Register word, bit 0 on the left
  typedef logic [0:15] bcs_word_type;

  // ===================================================================
  // Hard-reset configuration layout, first field is bit 0
  typedef struct packed {
    logic external_arbitration;
    logic interrupt_prefix_sel;
    logic rsv2;
    logic boot_disable;
    logic [1:0] boot_port_size;
    logic rsv6;
    logic [1:0] initial_space_base;
    logic [1:0] debug_pin_config;
    logic [1:0] debug_port_location;
    logic [1:0] ext_bus_div_factor;
    logic rsv15;
  } bcs_hrc_type;

  // ===================================================================
  // Field encodings, in code order 00 to 11
  typedef enum logic [1:0] {
    BCS_PORT_32, BCS_PORT_8, BCS_PORT_16, BCS_PORT_RSVD
  } bcs_port_type;

  typedef enum logic [1:0] {
    BCS_PINS_CARD2, BCS_PINS_WATCH, BCS_PINS_RSVD, BCS_PINS_SHOW
  } bcs_pins_type;

  typedef enum logic [1:0] {
    BCS_DPORT_JTAG, BCS_DPORT_NONE, BCS_DPORT_RSVD, BCS_DPORT_CARD2
  } bcs_dport_type;

  // ===================================================================
  // Configuration as the processor takes it at hard reset
  typedef struct packed {
    logic ext_arb;
    logic [31:0] int_prefix;
    logic boot_cs_en;
    bcs_port_type boot_port;
    logic [31:0] map_base;
    bcs_pins_type dbg_pins;
    bcs_dport_type dbg_port;
    logic clk_div2;
  } bcs_cfg_type;

  // ===================================================================
  // One bus request as seen in a cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] idx;
    bcs_word_type wdata;
  } bcs_req_type;

endpackage

// ==== bcs_regs.sv ====
/*
  Board control and status register file: five 16-bit registers on the
  upper half of a 32-bit host bus, mirrored through one chip-select
  region, with one-shot protection of the unmapping bit and drive of
  the hard-reset configuration word onto the data bus.
  Assumes a synchronous host bus with active-low chip select and
  strobes, and a host bus of 32 data lines of which 31..16 carry data.
*/
`timescale 1ns/1ps
`default_nettype none

`include "bcs_params.svh"

module bcs_regs
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hard_reset_n,
  input wire logic regfile_chip_select_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [`BCS_ADDR_MSB:2] bus_addr,
  input wire logic [31:0] bus_data_in,
  output logic [31:0] bus_data_out_q,
  output logic bus_data_oe_q,
  output logic regfile_mapped_q,
  output bcs_hrc_type hrc_q,
  output bcs_cfg_type active_cfg_q,
  output logic [0:31] enable_onboard_q,
  output logic [0:31] enable_connector_q
);

  // ===================================================================
  // Storage
  bcs_word_type regs_q [0:4];
  bcs_word_type second_d;
  bcs_word_type fourth_d;
  bcs_word_type cfg_src;
  bcs_req_type req;
  logic mapped;
  logic flash_src;
  logic cfg_drive;
  logic rd_hit;
  logic wr_hit;

  // ===================================================================
  // Functions

  // Register slot from the word address; higher bits are ignored
  function automatic logic [2:0] word_index(
    input logic [`BCS_ADDR_MSB:2] a
  );
    return a[`BCS_IDX_MSB:`BCS_IDX_LSB];
  endfunction

  // Read value of a slot; slots past the fifth read zero
  function automatic bcs_word_type read_word(input logic [2:0] idx);
    bcs_word_type w;
    w = '0;
    case (idx)
      `BCS_OFS_HRC: begin
        w = regs_q[0];
      end
      `BCS_OFS_SECOND: begin
        w = regs_q[1];
      end
      `BCS_OFS_THIRD: begin
        w = regs_q[2];
      end
      `BCS_OFS_FOURTH: begin
        w = regs_q[3];
        w[`BCS_R3_UNLOCK] = regs_q[1][`BCS_R1_UNLOCK];
      end
      `BCS_OFS_FIFTH: begin
        w = regs_q[4];
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // Turns a configuration word into the values the processor adopts
  function automatic bcs_cfg_type decode_cfg(input bcs_word_type w);
    bcs_hrc_type h;
    bcs_cfg_type c;
    h = bcs_hrc_type'(w);
    c = '0;
    // Arbitration and interrupt prefix
    c.ext_arb = h.external_arbitration;
    if (h.interrupt_prefix_sel) begin
      c.int_prefix = `BCS_IPFX_LO;
    end else begin
      c.int_prefix = `BCS_IPFX_HI;
    end
    // Boot chip select and its port size
    c.boot_cs_en = ~h.boot_disable;
    c.boot_port = bcs_port_type'(h.boot_port_size);
    // Base of the internal map
    case (h.initial_space_base)
      2'h0: begin
        c.map_base = `BCS_BASE_00;
      end
      2'h1: begin
        c.map_base = `BCS_BASE_01;
      end
      default: begin
        c.map_base = `BCS_BASE_1X;
      end
    endcase
    // Debug pins and debug port
    c.dbg_pins = bcs_pins_type'(h.debug_pin_config);
    c.dbg_port = bcs_dport_type'(h.debug_port_location);
    // Only code 01 divides the bus clock by two
    c.clk_div2 = (h.ext_bus_div_factor == 2'h1);
    return c;
  endfunction

  // ===================================================================
  // Request decode

  // Gather the strobes into one request
  always_comb begin
    req.rd = ~regfile_chip_select_n & ~bus_rd_n;
    req.wr = ~regfile_chip_select_n & ~bus_wr_n;
    req.idx = word_index(bus_addr);
    req.wdata = bus_data_in[`BCS_DATA_MSB:`BCS_DATA_LSB];
  end

  // Access is only taken while mapped and out of hard reset
  assign mapped = ~regs_q[1][`BCS_R1_MAPEN];
  assign rd_hit = req.rd & mapped & hard_reset_n;
  assign wr_hit = req.wr & mapped & hard_reset_n;

  // Configuration source and drive condition
  assign flash_src = ~regs_q[1][`BCS_R1_FLASH_CFG];
  assign cfg_drive = ~hard_reset_n & ~flash_src;

  // ===================================================================
  // Second register write value with the protected bits

  // Unmap only after an unlock; no path back to mapped
  always_comb begin
    second_d = req.wdata;
    if (regs_q[1][`BCS_R1_UNLOCK]) begin
      second_d[`BCS_R1_MAPEN] = regs_q[1][`BCS_R1_MAPEN] |
        req.wdata[`BCS_R1_MAPEN];
    end else begin
      second_d[`BCS_R1_MAPEN] = regs_q[1][`BCS_R1_MAPEN];
    end
    // Any write here re-arms the protection
    second_d[`BCS_R1_UNLOCK] = 1'b0;
  end

  // Fourth register keeps no copy of the unlock bit
  always_comb begin
    fourth_d = req.wdata;
    fourth_d[`BCS_R3_UNLOCK] = 1'b0;
  end

  // ===================================================================
  // Configuration word, reset only by power-on

  // Hard reset leaves it alone; writes wait for the next hard reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs_q[0] <= `BCS_HRC_RESET;
    end else if (wr_hit && req.idx == `BCS_OFS_HRC) begin
      regs_q[0] <= req.wdata;
    end
  end

  // ===================================================================
  // Second register: enables, flash source, unlock, map enable

  // Wakes up mapped and locked
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs_q[1] <= `BCS_R1_RESET;
    end else if (wr_hit && req.idx == `BCS_OFS_SECOND) begin
      regs_q[1] <= second_d;
    end else if (wr_hit && req.idx == `BCS_OFS_FOURTH) begin
      regs_q[1][`BCS_R1_UNLOCK] <= req.wdata[`BCS_R3_UNLOCK];
    end
  end

  // ===================================================================
  // Third and fifth registers: plain storage; fourth stores all but bit 0, which sets the unlock bit

  // Third register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs_q[2] <= `BCS_R2_RESET;
    end else if (wr_hit && req.idx == `BCS_OFS_THIRD) begin
      regs_q[2] <= req.wdata;
    end
  end

  // Fourth register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs_q[3] <= `BCS_R3_RESET;
    end else if (wr_hit && req.idx == `BCS_OFS_FOURTH) begin
      regs_q[3] <= fourth_d;
    end
  end

  // Fifth register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs_q[4] <= `BCS_R4_RESET;
    end else if (wr_hit && req.idx == `BCS_OFS_FIFTH) begin
      regs_q[4] <= req.wdata;
    end
  end

  // ===================================================================
  // Data bus drive

  // Configuration drive wins over any read; lower lines read zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_data_out_q <= 32'h00000000;
      bus_data_oe_q <= 1'b0;
    end else if (cfg_drive) begin
      bus_data_out_q <= {regs_q[0], 16'h0000};
      bus_data_oe_q <= 1'b1;
    end else if (rd_hit) begin
      bus_data_out_q <= {read_word(req.idx), 16'h0000};
      bus_data_oe_q <= 1'b1;
    end else begin
      bus_data_out_q <= 32'h00000000;
      bus_data_oe_q <= 1'b0;
    end
  end

  // ===================================================================
  // Configuration the processor adopts at hard reset

  // Flash word replaces the register when the flash source is chosen
  always_comb begin
    if (flash_src) begin
      cfg_src = bus_data_in[`BCS_DATA_MSB:`BCS_DATA_LSB];
    end else begin
      cfg_src = regs_q[0];
    end
  end

  // Follows the source through hard reset, holds after release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_cfg_q <= decode_cfg(`BCS_HRC_RESET);
    end else if (!hard_reset_n) begin
      active_cfg_q <= decode_cfg(cfg_src);
    end
  end

  // ===================================================================
  // Board-side outputs

  // Enables reach onboard modules and connectors alike
  always_comb begin
    regfile_mapped_q = mapped;
    hrc_q = bcs_hrc_type'(regs_q[0]);
    enable_onboard_q = {regs_q[1], regs_q[2]};
    enable_connector_q = {regs_q[1], regs_q[2]};
  end

endmodule

`default_nettype wire

// ==== bcs_regs_sva.sv ====
/* Port checker of the register file.
   Assumes bcs_pkg is compiled first; bound into bcs_regs below. */
`timescale 1ns/1ps
`default_nettype none
module bcs_regs_sva
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hard_reset_n,
  input wire logic regfile_chip_select_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [14:2] bus_addr,
  input wire logic [31:0] bus_data_in,
  input wire logic [31:0] bus_data_out_q,
  input wire logic bus_data_oe_q,
  input wire logic regfile_mapped_q,
  input wire bcs_hrc_type hrc_q,
  input wire bcs_cfg_type active_cfg_q,
  input wire logic [0:31] enable_onboard_q,
  input wire logic [0:31] enable_connector_q
);
  // ==================================================================
  // Helpers
  logic go;
  logic [15:0] wd_q;
  // Access that the block takes
  assign go = !regfile_chip_select_n && regfile_mapped_q && hard_reset_n;
  // Write word one cycle back
  always_ff @(posedge clk) begin
    wd_q <= bus_data_in[31:16];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==================================================================
  // Properties
  AST_RD_ANSWER: assert property (go && !bus_rd_n |=> bus_data_oe_q)
    else $error("read not answered");
  AST_OE_CAUSE: assert property (bus_data_oe_q |-> !$past(bus_rd_n) ||
    !$past(hard_reset_n) || !$past(hard_reset_n, 2)) else $error("stray drive");
  AST_RD_HRC: assert property (go && !bus_rd_n && bus_addr[4:2] == 3'h0
    |=> bus_data_out_q == {$past(hrc_q), 16'h0000}) else $error("bad config read");
  AST_HRC_WR: assert property (go && !bus_wr_n && bus_addr[4:2] == 3'h0
    |=> hrc_q == wd_q) else $error("config write lost");
  AST_HR_DRIVE: assert property (!hard_reset_n [*3] ##0 enable_onboard_q[4]
    |-> bus_data_oe_q && bus_data_out_q == {hrc_q, 16'h0000}) else $error("no drive");
  AST_FLASH_QUIET: assert property (!hard_reset_n [*3] ##0 !enable_onboard_q[4]
    |-> !bus_data_oe_q) else $error("drive with flash source");
  AST_CFG_BASE: assert property (!hard_reset_n && enable_onboard_q[4] &&
    hrc_q.initial_space_base == 2'h1 |=> active_cfg_q.map_base == 32'h00f00000)
    else $error("bad map base");
  AST_CFG_HOLD: assert property (hard_reset_n && $past(hard_reset_n) &&
    $past(hard_reset_n, 2) && $past(reset_n) |-> $stable(active_cfg_q))
    else $error("config moved");
  AST_MAP_STUCK: assert property (!regfile_mapped_q |=> !regfile_mapped_q)
    else $error("remapped");
  AST_LOCKED: assert property (!enable_onboard_q[5] |=> regfile_mapped_q ||
    !$past(regfile_mapped_q)) else $error("locked unmap");
  AST_RELOCK: assert property (go && !bus_wr_n && bus_addr[4:2] == 3'h1
    |=> !enable_onboard_q[5]) else $error("no relock");
  AST_COPY: assert property (enable_onboard_q == enable_connector_q)
    else $error("enable copies differ");
  // ==================================================================
  // Coverage
  cover property (go && !bus_wr_n && bus_addr[4:2] == 3'h3);
  cover property (!regfile_mapped_q);
  cover property (!hard_reset_n && bus_data_oe_q);
endmodule
bind bcs_regs bcs_regs_sva chk (.*);
`default_nettype wire

// ==== bcs_bus_model.sv ====
/* Host side data wire with the boot flash.
   Assumes one host and one device driver. */
`timescale 1ns/1ps
`default_nettype none
module bcs_bus_model #(
  parameter logic [15:0] FLASH_WORD = 16'h5aa5
) (
  input wire logic clk,
  input wire logic hard_reset_n,
  input wire logic host_oe,
  input wire logic [31:0] host_data,
  input wire logic dev_oe,
  input wire logic [31:0] dev_data,
  output logic [31:0] bus
);
  logic [31:0] last_q = 32'h0;
  // Wire level; no pull, so a free wire shows the inverse of its last value
  always_comb begin
    if (dev_oe) bus = dev_data;
    else if (host_oe) bus = host_data;
    else if (!hard_reset_n) bus = {FLASH_WORD, 16'h0000};
    else bus = ~last_q;
  end
  // Last level seen
  always_ff @(posedge clk) last_q <= bus;
endmodule
`default_nettype wire

// ==== board_control_status_regs_tb.sv ====
/* Testbench: host bus tasks and register sequences.
   Assumes bcs_regs, bcs_bus_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module board_control_status_regs_tb
  import bcs_pkg::*;
;
  logic clk = 1'h0, reset_n = 1'h0, hrst_n = 1'h1, cs_n = 1'h1, rd_n = 1'h1, wr_n = 1'h1;
  logic host_oe = 1'h0, oe, mapped;
  logic [14:2] addr = 13'h0;
  logic [31:0] host_d = 32'h0, bus, dout;
  logic [0:31] en_on, en_con;
  bcs_hrc_type hrc;
  bcs_cfg_type acfg;
  int fails = 0, checks_done = 0;
  // Clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  bcs_bus_model pm (.clk(clk), .hard_reset_n(hrst_n), .host_oe(host_oe),
    .host_data(host_d), .dev_oe(oe), .dev_data(dout), .bus(bus));
  bcs_regs uut (.clk(clk), .reset_n(reset_n), .hard_reset_n(hrst_n),
    .regfile_chip_select_n(cs_n), .bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_addr(addr),
    .bus_data_in(bus), .bus_data_out_q(dout), .bus_data_oe_q(oe),
    .regfile_mapped_q(mapped), .hrc_q(hrc), .active_cfg_q(acfg),
    .enable_onboard_q(en_on), .enable_connector_q(en_con));
  // ==================================================================
  // Tasks
  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [72:0] g, input logic [72:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [31:0] d);
    @(posedge clk);
    {cs_n, wr_n, host_oe} <= 3'h1;
    addr <= a[14:2];
    host_d <= d;
    @(posedge clk);
    {cs_n, wr_n, host_oe} <= 3'h6;
    @(posedge clk);
  endtask
  task automatic rd(input logic [14:0] a, input logic [31:0] e, input bit none = 1'h0);
    int n;
    @(posedge clk);
    {cs_n, rd_n} <= 2'h0;
    addr <= a[14:2];
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (oe !== 1'h1 && n < 6);
    {cs_n, rd_n} <= 2'h3;
    cmp(oe, !none);
    if (!none && oe !== 1'h1) results();
    if (!none) cmp(dout, e);
  endtask
  // Drive a hard reset and look at the bus and the adopted setup
  task automatic hard(input logic drive, input logic [31:0] w, input bcs_cfg_type e);
    @(posedge clk);
    hrst_n <= 1'h0;
    repeat (4) @(posedge clk);
    cmp(oe, drive);
    if (drive) cmp(dout, w);
    hrst_n <= 1'h1;
    repeat (3) @(posedge clk);
    cmp(oe, 1'h0);
    cmp(acfg, e);
  endtask
  // Setup the processor takes from a configuration word
  function automatic bcs_cfg_type dec(input bcs_hrc_type h);
    dec.ext_arb = h.external_arbitration;
    dec.int_prefix = h.interrupt_prefix_sel ? 32'h0 : 32'hfff00000;
    dec.boot_cs_en = !h.boot_disable;
    dec.boot_port = bcs_port_type'(h.boot_port_size);
    dec.map_base = h.initial_space_base[1] ? 32'hff000000 :
      h.initial_space_base[0] ? 32'h00f00000 : 32'h0;
    dec.dbg_pins = bcs_pins_type'(h.debug_pin_config);
    dec.dbg_port = bcs_dport_type'(h.debug_port_location);
    dec.clk_div2 = h.ext_bus_div_factor == 2'h1;
  endfunction
  // ==================================================================
  // Sequence
  initial begin
    bcs_hrc_type h;
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    rd(15'h0, 32'h01000000);
    rd(15'h4, 32'h39b00000);
    rd(15'h14, 32'h0);
    wr(15'h8, 32'h12340000);
    for (int k = 0; k < 4; k++) begin
      h = {k[1], k[0], k[0], k[1], k[1:0], k[1], k[1:0], k[1:0], k[1:0], k[1:0], k[0]};
      wr(15'h7fe0, {h, 16'hffff});
      rd(15'h0, {h, 16'h0});
      hard(1'h1, {h, 16'h0}, dec(h));
      cmp(hrc, h);
    end
    wr(15'h4, 32'h31b00000);
    hard(1'h0, 32'h0, dec(16'h5aa5));
    wr(15'h4, 32'h3bb00000);
    cmp(mapped, 1'h1);
    wr(15'hc, 32'h80000000);
    rd(15'h4, 32'h3db00000);
    wr(15'h4, 32'h39b00000);
    rd(15'hc, 32'h0);
    wr(15'h4, 32'h3bb00000);
    cmp(mapped, 1'h1);
    wr(15'hc, 32'h80000000);
    wr(15'h4, 32'h3bb00000);
    cmp(mapped, 1'h0);
    rd(15'h0, 32'h0, 1'h1);
    wr(15'h4, 32'h39b00000);
    cmp(mapped, 1'h0);
    cmp(en_on, {16'h3bb0, 16'h1234});
    cmp(en_con, {16'h3bb0, 16'h1234});
    hard(1'h1, {h, 16'h0}, dec(h));
    reset_n <= 1'h0;
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    rd(15'h0, 32'h01000000);
    results();
  end
endmodule
`default_nettype wire
